// *** iox_pkg.sv ***
// package for the eight-pin expander with keypad scanner
// assumes a single 125 MHz clock and a byte-wide register port
package iox_pkg;
   localparam int unsigned CLK_HZ = 125_000_000;
   localparam int unsigned DEB_US = 75;
   localparam int unsigned DEB_CYC = (DEB_US * (CLK_HZ / 1_000_000));
   localparam int unsigned SCAN_MS = 25;
   localparam int unsigned SCAN_CYC = SCAN_MS * (CLK_HZ / 1000);
   localparam int unsigned SETTLE_CYC = 16;

   localparam logic [7:0] A_MODE   = 8'h00;
   localparam logic [7:0] A_IEN    = 8'h01;
   localparam logic [7:0] A_BLCTL  = 8'h02;
   localparam logic [7:0] A_LEDEN  = 8'h11;
   localparam logic [7:0] A_SCAN   = 8'h17;
   localparam logic [7:0] A_DIR    = 8'h18;
   localparam logic [7:0] A_INST   = 8'h19;
   localparam logic [7:0] A_OUTD   = 8'h1A;
   localparam logic [7:0] A_GIEN   = 8'h1B;
   localparam logic [7:0] A_GIST   = 8'h1C;
   localparam logic [7:0] A_GILV   = 8'h1D;
   localparam logic [7:0] A_DBDIS  = 8'h1E;
   localparam logic [7:0] A_PULL   = 8'h1F;
   localparam logic [7:0] A_KPAH   = 8'h20;
   localparam logic [7:0] A_KPIP   = 8'h21;
   localparam logic [7:0] A_KRAH   = 8'h22;
   localparam logic [7:0] A_KRIP   = 8'h23;

   // mode register fields
   localparam int unsigned B_STNBY  = 7;
   localparam int unsigned B_BLEN   = 5;
   localparam int unsigned B_GPIINT = 2;
   localparam int unsigned B_KRINT  = 1;
   localparam int unsigned B_KPINT  = 0;
   // interrupt enable fields
   localparam int unsigned B_KRIEN  = 1;
   localparam int unsigned B_KPIEN  = 0;
   // backlight control fields
   localparam int unsigned B_KPBL   = 1;
   // led enable fields releasing row 3 / column 3
   localparam int unsigned B_R3SEL  = 4;
   localparam int unsigned B_C3SEL  = 5;
   localparam logic [7:0]  RST_VAL  = 8'h00;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } iox_req_s;

   typedef enum logic [1:0] {
      SC_IDLE  = 2'b00,
      SC_PRESS = 2'b01,
      SC_HELD  = 2'b11,
      SC_REL   = 2'b10
   } iox_scan_e;
endpackage : iox_pkg

// *** iox_top.sv ***
// expander pins, debounce, gpio interrupts, keypad scanner, status registers
// assumes a serial-interface front end presents one-cycle rd/wr strobes;
// the off-timer expiry arrives as a pulse from the backlight block
// Operation
// RULE_01 - each pin is input, input with pull-up, or output
// RULE_02 - row 3 and column 3 are led sinks until led enable bits 4,5 set
// RULE_03 - output pins drive the output data register bit
// RULE_04 - per-pin pull-up from the pull-up control register
// RULE_05 - 75 us debounce per input, on by default, disable per pin
// RULE_06 - input state register shows sensed level of inputs
// RULE_07 - enabled inputs at chosen level latch into input interrupt status
// RULE_08 - any input status bit sets master input flag and asserts interrupt
// RULE_09 - input status cleared by reads once condition ends; write one clears flag
// RULE_10 - keypad uses four rows, four columns, keys A to P
// RULE_11 - host enables row pull-ups before enabling scanning
// RULE_12 - idle scanner holds rows pulled up, columns low, starts on a low row
// RULE_13 - sample every 25 ms, press needs two consecutive pressed samples
// RULE_14 - release needs two consecutive open samples, then back to idle
// RULE_15 - press latches per-key bit, master press flag gated by its enable
// RULE_16 - press registers clear on read, write one clears press flag
// RULE_17 - press flag clears even while key still held
// RULE_18 - release latches per-key bit, master release flag gated by enable
// RULE_19 - release registers clear on read, write one clears release flag
// RULE_20 - registered press lights backlight when enabled; off on timer or host
// RULE_21 - host sets pull-ups, scanning, light enable, then operating mode
// RULE_22 - new press relights only after both master flags cleared
// RULE_23 - state machine sets backlight enable itself on press
// RULE_24 - interrupt output active low, open drain
// RULE_25 - scanning pins ignore gpio output and interrupt settings
module iox_top
   import iox_pkg::*;
#(
   parameter int unsigned DEB_CYCLES  = DEB_CYC,
   parameter int unsigned SCAN_CYCLES = SCAN_CYC
) (
   input  wire logic       CLOCK,
   input  wire logic       SRST,
   input  wire logic       REG_WR,
   input  wire logic       REG_RD,
   input  wire logic [7:0] REG_ADDR,
   input  wire logic [7:0] REG_WDATA,
   output logic      [7:0] REG_RDATA,
   input  wire logic       OFF_TIMER_EXPIRED,
   input  wire logic [7:0] PIN_IN,
   output logic      [7:0] PIN_OUT,
   output logic      [7:0] PIN_OE,
   output logic      [7:0] PIN_PULLUP,
   output logic            LED2_SINK_SEL,
   output logic            LED3_SINK_SEL,
   output logic            BACKLIGHT_ENABLE,
   output logic            INTERRUPT_OUT_N_OUT,
   output logic            INTERRUPT_OUT_N_OE
);
   if (DEB_CYCLES < 2 || SCAN_CYCLES < 4 * SETTLE_CYC + 4) begin : g_bad_counts
      $error("iox_top: counts too small");
   end

   iox_req_s req;
   assign req = '{wr: REG_WR, rd: REG_RD, addr: REG_ADDR, wdata: REG_WDATA};

   function automatic logic hit(input iox_req_s r, input logic [7:0] a);
      return r.addr == a;
   endfunction : hit

   // register state
   logic [7:0] mode_q, mode_d, ien_q, ien_d, blctl_q, blctl_d, leden_q, leden_d;
   logic [7:0] scan_q, scan_d, outd_q, outd_d, gien_q, gien_d, gist_q, gist_d;
   logic [7:0] gilv_q, gilv_d, dbdis_q, dbdis_d, pull_q, pull_d;
   logic [15:0] kp_q, kp_d, kr_q, kr_d;
   logic [7:0] rdata_q, rdata_d;
   logic       relight_ok_q, relight_ok_d;
   // pin direction: a set bit makes the pin an output
   logic [7:0] outd_dir_q, outd_dir_d;

   // pin usability: row 3 is pin 3, column 3 is pin 7
   logic [7:0] avail, scan_pin, gp_in;
   always_comb begin
      avail = 8'hFF;
      // RULE_02 sink pins gated
      avail[3] = leden_q[B_R3SEL];
      avail[7] = leden_q[B_C3SEL];
      // RULE_25 scanner owns pins
      scan_pin = scan_q & avail;
      gp_in    = avail & ~scan_pin & ~outd_dir_q;
   end
   assign LED3_SINK_SEL = ~leden_q[B_R3SEL];
   assign LED2_SINK_SEL = ~leden_q[B_C3SEL];

   // three-stage synchroniser
   logic [7:0] s1_q, s2_q, s3_q;
   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         s1_q <= 8'hFF;
         s2_q <= 8'hFF;
         s3_q <= 8'hFF;
      end else begin
         s1_q <= PIN_IN;
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   // debounce per pin
   logic [7:0] deb_q, deb_d;
   logic [7:0][$clog2(DEB_CYCLES+1)-1:0] dcnt_q, dcnt_d;
   always_comb begin
      deb_d  = deb_q;
      dcnt_d = dcnt_q;
      for (int i = 0; i < 8; i++) begin
         if (s2_q[i] != s3_q[i]) begin
            dcnt_d[i] = '0;
         end else if (s3_q[i] == deb_q[i]) begin
            dcnt_d[i] = '0;
         // RULE_05 filter or bypass
         end else if (dbdis_q[i]) begin
            deb_d[i] = s3_q[i];
         end else if (dcnt_q[i] >= $bits(dcnt_q[i])'(DEB_CYCLES - 1)) begin
            deb_d[i]  = s3_q[i];
            dcnt_d[i] = '0;
         end else begin
            dcnt_d[i] = dcnt_q[i] + 1'b1;
         end
      end
   end
   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         deb_q  <= 8'hFF;
         dcnt_q <= '0;
      end else begin
         deb_q  <= deb_d;
         dcnt_q <= dcnt_d;
      end
   end

   // scanner: rows pins 0..3, columns pins 4..7
   iox_scan_e st_q, st_d;
   logic [$clog2(SCAN_CYCLES+1)-1:0] tmr_q, tmr_d;
   logic [3:0] cdrv_q, cdrv_d;
   logic [15:0] samp_q, samp_d, prev_q, prev_d, held_q, held_d;
   logic        tick, kp_ev, scan_on;
   logic [15:0] new_press, new_rel;
   logic [1:0]  col_q, col_d;
   assign scan_on = |scan_pin[3:0] && |scan_pin[7:4];
   assign tick    = tmr_q == '0;
   always_comb begin
      st_d      = st_q;
      tmr_d     = tmr_q;
      cdrv_d    = 4'h0;
      samp_d    = samp_q;
      prev_d    = prev_q;
      held_d    = held_q;
      col_d     = col_q;
      new_press = 16'h0000;
      new_rel   = 16'h0000;
      unique case (st_q)
         // RULE_12 idle wait on row
         SC_IDLE: begin
            tmr_d = '0;
            if (scan_on && |(~deb_q[3:0] & scan_pin[3:0])) begin
               st_d  = SC_PRESS;
               tmr_d = $bits(tmr_d)'(SCAN_CYCLES - 1);
            end
         end
         SC_PRESS, SC_HELD, SC_REL: begin
            tmr_d = tick ? $bits(tmr_d)'(SCAN_CYCLES - 1) : tmr_q - 1'b1;
            // sweep: drive one column low at a time during the last slots before each tick
            cdrv_d = 4'hF;
            if (tmr_q < $bits(tmr_q)'(4 * SETTLE_CYC)) begin
               col_d = 2'(tmr_q / SETTLE_CYC);
               cdrv_d = 4'hF & ~(4'h1 << col_d);
               if (tmr_q % SETTLE_CYC == 1) begin
                  // RULE_10 key index column times four plus row
                  // slots are far shorter than the debounce, so read agreeing sync stages
                  for (int r = 0; r < 4; r++) begin
                     samp_d[col_d*4+r] = ~s2_q[r] & ~s3_q[r] & scan_pin[r];
                  end
               end
            end
            // RULE_13 two-sample press
            if (tick) begin
               new_press = samp_q & prev_q & ~held_q;
               // RULE_14 two-sample release
               new_rel   = ~samp_q & ~prev_q & held_q;
               held_d    = (held_q | new_press) & ~new_rel;
               prev_d    = samp_q;
               samp_d    = 16'h0000;
               st_d      = (|held_d || |samp_q) ? SC_HELD : SC_REL;
               if (!(|held_d) && !(|samp_q) && !(|prev_q)) begin
                  st_d = SC_IDLE;
               end
            end
            if (!scan_on) begin
               st_d   = SC_IDLE;
               held_d = 16'h0000;
               prev_d = 16'h0000;
               samp_d = 16'h0000;
            end
         end
      endcase
   end
   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         st_q   <= SC_IDLE;
         tmr_q  <= '0;
         cdrv_q <= 4'h0;
         samp_q <= 16'h0000;
         prev_q <= 16'h0000;
         held_q <= 16'h0000;
         col_q  <= 2'b00;
      end else begin
         st_q   <= st_d;
         tmr_q  <= tmr_d;
         cdrv_q <= cdrv_d;
         samp_q <= samp_d;
         prev_q <= prev_d;
         held_q <= held_d;
         col_q  <= col_d;
      end
   end
   assign kp_ev = |new_press;

   // pin drivers
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         // RULE_01 RULE_03 gpio output
         PIN_OUT[i]    = outd_q[i];
         PIN_OE[i]     = avail[i] & ~scan_pin[i] & outd_dir_q[i];
         // RULE_04 per-pin pull-up
         PIN_PULLUP[i] = avail[i] & pull_q[i];
      end
      // RULE_12 columns low while idle, swept during scan
      for (int c = 0; c < 4; c++) begin
         if (scan_pin[4+c]) begin
            PIN_OUT[4+c] = (st_q == SC_IDLE) ? 1'b0 : cdrv_q[c];
            PIN_OE[4+c]  = (st_q == SC_IDLE) ? 1'b1 : ~cdrv_q[c];
         end
      end
   end

   // gpio interrupt conditions
   logic [7:0] gp_cond;
   // RULE_07 level and enable
   assign gp_cond = gp_in & gien_q & ~(deb_q ^ gilv_q);

   // register update
   logic        gp_flag, kp_flag, kr_flag;
   always_comb begin
      mode_d = mode_q; ien_d = ien_q; blctl_d = blctl_q; leden_d = leden_q;
      scan_d = scan_q; outd_d = outd_q; gien_d = gien_q; gilv_d = gilv_q;
      dbdis_d = dbdis_q; pull_d = pull_q; outd_dir_d = outd_dir_q;
      relight_ok_d = relight_ok_q;
      gist_d = gist_q; kp_d = kp_q; kr_d = kr_q;
      rdata_d = rdata_q;
      if (req.rd) begin
         unique case (1'b1)
            hit(req, A_MODE):  rdata_d = mode_q;
            hit(req, A_IEN):   rdata_d = ien_q;
            hit(req, A_BLCTL): rdata_d = blctl_q;
            hit(req, A_LEDEN): rdata_d = leden_q;
            hit(req, A_SCAN):  rdata_d = scan_q;
            // RULE_06 sensed inputs
            hit(req, A_INST):  rdata_d = deb_q & gp_in;
            hit(req, A_OUTD):  rdata_d = outd_q;
            hit(req, A_GIEN):  rdata_d = gien_q;
            hit(req, A_GIST):  rdata_d = gist_q;
            hit(req, A_GILV):  rdata_d = gilv_q;
            hit(req, A_DBDIS): rdata_d = dbdis_q;
            hit(req, A_PULL):  rdata_d = pull_q;
            hit(req, A_KPAH):  rdata_d = kp_q[7:0];
            hit(req, A_KPIP):  rdata_d = kp_q[15:8];
            hit(req, A_KRAH):  rdata_d = kr_q[7:0];
            hit(req, A_KRIP):  rdata_d = kr_q[15:8];
            hit(req, A_DIR):   rdata_d = outd_dir_q;
            default:           rdata_d = 8'h00;
         endcase
         // RULE_09 RULE_16 RULE_19 read clears
         if (hit(req, A_GIST)) gist_d = 8'h00;
         if (hit(req, A_KPAH)) kp_d[7:0] = 8'h00;
         if (hit(req, A_KPIP)) kp_d[15:8] = 8'h00;
         if (hit(req, A_KRAH)) kr_d[7:0] = 8'h00;
         if (hit(req, A_KRIP)) kr_d[15:8] = 8'h00;
      end
      if (req.wr) begin
         if (hit(req, A_MODE)) begin
            mode_d[7:3] = req.wdata[7:3];
            // write one clears a master flag only once its sources are empty
            for (int b = 0; b < 3; b++) begin
               if (req.wdata[b]) mode_d[b] = 1'b0;
            end
         end
         if (hit(req, A_IEN))   ien_d   = req.wdata;
         if (hit(req, A_BLCTL)) blctl_d = req.wdata;
         if (hit(req, A_LEDEN)) leden_d = req.wdata;
         if (hit(req, A_SCAN))  scan_d  = req.wdata;
         if (hit(req, A_OUTD))  outd_d  = req.wdata;
         if (hit(req, A_GIEN))  gien_d  = req.wdata;
         if (hit(req, A_GILV))  gilv_d  = req.wdata;
         if (hit(req, A_DBDIS)) dbdis_d = req.wdata;
         if (hit(req, A_PULL))  pull_d  = req.wdata;
         if (hit(req, A_DIR))   outd_dir_d = req.wdata;
      end
      // events set after clears: set wins
      gist_d = gist_d | gp_cond;
      kp_d   = kp_d | new_press;
      kr_d   = kr_d | new_rel;
      // RULE_08 RULE_15 RULE_18 master flags follow status
      if (|gist_d)  mode_d[B_GPIINT] = 1'b1;
      if (|kp_d)    mode_d[B_KPINT]  = 1'b1;
      if (|kr_d)    mode_d[B_KRINT]  = 1'b1;
      // RULE_22 relight after both flags clear
      if (!mode_d[B_KPINT] && !mode_d[B_KRINT]) relight_ok_d = 1'b1;
      // RULE_20 RULE_23 press lights backlight
      if (kp_ev && blctl_q[B_KPBL] && mode_q[B_STNBY] && relight_ok_q) begin
         mode_d[B_BLEN] = 1'b1;
         relight_ok_d   = 1'b0;
      end else if (OFF_TIMER_EXPIRED) begin
         mode_d[B_BLEN] = 1'b0;
      end
   end
   always_ff @(posedge CLOCK) begin
      if (SRST) begin
         mode_q <= RST_VAL; ien_q <= RST_VAL; blctl_q <= RST_VAL; leden_q <= RST_VAL;
         scan_q <= RST_VAL; outd_q <= RST_VAL; gien_q <= RST_VAL; gilv_q <= RST_VAL;
         dbdis_q <= RST_VAL; pull_q <= RST_VAL; outd_dir_q <= RST_VAL;
         gist_q <= RST_VAL; kp_q <= 16'h0000; kr_q <= 16'h0000;
         rdata_q <= RST_VAL; relight_ok_q <= 1'b1;
      end else begin
         mode_q <= mode_d; ien_q <= ien_d; blctl_q <= blctl_d; leden_q <= leden_d;
         scan_q <= scan_d; outd_q <= outd_d; gien_q <= gien_d; gilv_q <= gilv_d;
         dbdis_q <= dbdis_d; pull_q <= pull_d; outd_dir_q <= outd_dir_d;
         gist_q <= gist_d; kp_q <= kp_d; kr_q <= kr_d;
         rdata_q <= rdata_d; relight_ok_q <= relight_ok_d;
      end
   end

   assign gp_flag = mode_q[B_GPIINT];
   // RULE_17 press flag independent of held key
   assign kp_flag = mode_q[B_KPINT] & ien_q[B_KPIEN];
   assign kr_flag = mode_q[B_KRINT] & ien_q[B_KRIEN];
   assign REG_RDATA = rdata_q;
   assign BACKLIGHT_ENABLE = mode_q[B_BLEN];
   // RULE_24 open-drain active low
   assign INTERRUPT_OUT_N_OUT = 1'b0;
   assign INTERRUPT_OUT_N_OE  = gp_flag | kp_flag | kr_flag;

   // assertions
   // RULE_24 drive low only
   a_int_drive: assert property (@(posedge CLOCK) disable iff (SRST)
      (|gist_q || (|kp_q && ien_q[B_KPIEN]) || (|kr_q && ien_q[B_KRIEN]))
      |-> INTERRUPT_OUT_N_OE && !INTERRUPT_OUT_N_OUT)
      else $error("interrupt drive wrong"); // RULE_24
   a_gpi_flag: assert property (@(posedge CLOCK) disable iff (SRST)
      |gist_q |-> mode_q[B_GPIINT]) else $error("input flag missing"); // RULE_08
   a_gpi_latch: assert property (@(posedge CLOCK) disable iff (SRST)
      |gp_cond |=> |gist_q) else $error("input event lost"); // RULE_07
   a_kp_latch: assert property (@(posedge CLOCK) disable iff (SRST)
      kp_ev |=> ((kp_q & $past(new_press)) == $past(new_press)))
      else $error("press lost"); // RULE_15
   a_kr_latch: assert property (@(posedge CLOCK) disable iff (SRST)
      |new_rel |=> |kr_q && mode_q[B_KRINT]) else $error("release lost"); // RULE_18
   a_kp_rdclr: assert property (@(posedge CLOCK) disable iff (SRST)
      req.rd && hit(req, A_KPAH) && !kp_ev |=> kp_q[7:0] == 8'h00)
      else $error("press read did not clear"); // RULE_16
   a_gi_rdclr: assert property (@(posedge CLOCK) disable iff (SRST)
      req.rd && hit(req, A_GIST) && gp_cond == 8'h00 |=> gist_q == 8'h00)
      else $error("input read did not clear"); // RULE_09
   a_kr_rdclr: assert property (@(posedge CLOCK) disable iff (SRST)
      req.rd && hit(req, A_KRIP) && new_rel == 16'h0000 |=> kr_q[15:8] == 8'h00)
      else $error("release read did not clear"); // RULE_19
   a_bl_on: assert property (@(posedge CLOCK) disable iff (SRST)
      kp_ev && blctl_q[B_KPBL] && mode_q[B_STNBY] && relight_ok_q |=> BACKLIGHT_ENABLE)
      else $error("backlight not lit"); // RULE_23
   a_idle_cols: assert property (@(posedge CLOCK) disable iff (SRST)
      st_q == SC_IDLE && scan_pin[4] |-> PIN_OE[4] && !PIN_OUT[4])
      else $error("idle column not low"); // RULE_12
   a_sink_gate: assert property (@(posedge CLOCK) disable iff (SRST)
      !leden_q[B_R3SEL] |-> !PIN_OE[3] && !PIN_PULLUP[3])
      else $error("row 3 used as gpio"); // RULE_02
   c_press: cover property (@(posedge CLOCK) kp_ev);
   c_release: cover property (@(posedge CLOCK) |new_rel);
   c_gpi: cover property (@(posedge CLOCK) |gp_cond);
   c_relit: cover property (@(posedge CLOCK) kp_ev && relight_ok_q && blctl_q[B_KPBL]);
endmodule : iox_top

// *** iox_keypad_model.sv ***
// pin-side partner: 4x4 key switch matrix plus external signal sources
// assumes pins 0-3 are rows and 4-7 columns; a closed key joins its row and column
module iox_keypad_model (
   input  wire logic [7:0]  pin_out,
   input  wire logic [7:0]  pin_oe,
   input  wire logic [7:0]  pin_pullup,
   input  wire logic [15:0] key_closed,
   input  wire logic [7:0]  ext_level,
   output logic      [7:0]  pin_level
);
   always_comb begin
      // undriven pins follow the pull-up, else the external source
      for (int p = 0; p < 8; p++) begin
         pin_level[p] = pin_pullup[p] ? 1'b1 : ext_level[p];
      end
      // a driven column wins over a pulled-up row through a closed switch
      for (int c = 0; c < 4; c++) begin
         for (int r = 0; r < 4; r++) begin
            if (key_closed[c * 4 + r]) begin
               if (pin_oe[4 + c] && !pin_oe[r]) begin
                  pin_level[r] = pin_out[4 + c];
               end else if (pin_oe[r] && !pin_oe[4 + c]) begin
                  pin_level[4 + c] = pin_out[r];
               end
            end
         end
      end
      for (int p = 0; p < 8; p++) begin
         if (pin_oe[p]) begin
            pin_level[p] = pin_out[p];
         end
      end
   end
endmodule : iox_keypad_model

// *** testbench.sv ***
// self-checking bench for the expander with keypad scanner
// assumes short debounce and scan counts; the interrupt line has a pull-up
module testbench import iox_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic        CLOCK, SRST, REG_WR, REG_RD, OFF_TIMER_EXPIRED;
   logic [7:0]  REG_ADDR, REG_WDATA, REG_RDATA, PIN_IN, PIN_OUT, PIN_OE, PIN_PULLUP;
   logic        LED2_SINK_SEL, LED3_SINK_SEL, BACKLIGHT_ENABLE;
   logic        INTERRUPT_OUT_N_OUT, INTERRUPT_OUT_N_OE;
   logic [15:0] key_closed, e16;
   logic [7:0]  ext_level, rdv;
   logic [31:0] seed;
   logic        irq_n;
   int          n_fail = 0, check_count = 0, cycles = 0, key;
   logic [7:0]  shadow [0:255];
   int          key_q [$];
   logic [7:0]  alist [0:15] = '{A_MODE, A_IEN, A_BLCTL, A_LEDEN, A_SCAN, A_OUTD, A_GIEN,
      A_GIST, A_GILV, A_DBDIS, A_PULL, A_KPAH, A_KPIP, A_KRAH, A_KRIP, 8'h30};
   // open-drain line resolved against its external pull-up
   assign irq_n = INTERRUPT_OUT_N_OE ? INTERRUPT_OUT_N_OUT : 1'b1;
   iox_top #(.DEB_CYCLES(4), .SCAN_CYCLES(200)) dut (.CLOCK(CLOCK), .SRST(SRST),
      .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
      .REG_RDATA(REG_RDATA), .OFF_TIMER_EXPIRED(OFF_TIMER_EXPIRED), .PIN_IN(PIN_IN),
      .PIN_OUT(PIN_OUT), .PIN_OE(PIN_OE), .PIN_PULLUP(PIN_PULLUP),
      .LED2_SINK_SEL(LED2_SINK_SEL), .LED3_SINK_SEL(LED3_SINK_SEL),
      .BACKLIGHT_ENABLE(BACKLIGHT_ENABLE), .INTERRUPT_OUT_N_OUT(INTERRUPT_OUT_N_OUT),
      .INTERRUPT_OUT_N_OE(INTERRUPT_OUT_N_OE));
   iox_keypad_model keys (.pin_out(PIN_OUT), .pin_oe(PIN_OE), .pin_pullup(PIN_PULLUP),
      .key_closed(key_closed), .ext_level(ext_level), .pin_level(PIN_IN));
   initial begin
      CLOCK = 1'b0;
      forever #4 CLOCK = ~CLOCK;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s;
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction : xs
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : end_of_test
   // a hang counts as a mismatch
   always @(posedge CLOCK) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         end_of_test();
      end
   end
   task automatic step(input int n);
      repeat (n) @(posedge CLOCK);
      #1;
   endtask : step
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // strobe held one edge, then one idle edge so the next strobe is a fresh pulse
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      REG_ADDR = a;
      REG_WDATA = d;
      REG_WR = 1'b1;
      step(1);
      REG_WR = 1'b0;
      shadow[a] = d;
      step(1);
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      REG_ADDR = a;
      REG_RD = 1'b1;
      step(1);
      REG_RD = 1'b0;
      step(1);
      d = REG_RDATA;
   endtask : rd
   task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
      rd(a, rdv);
      chk(nm, e, rdv);
   endtask : rchk
   task automatic wait_irq(input logic lvl, input int lim);
      for (int i = 0; i < lim && irq_n !== lvl; i++) step(1);
      chk("irq line", {7'h00, lvl}, {7'h00, irq_n});
   endtask : wait_irq
   task automatic do_reset();
      SRST = 1'b1;
      step(4);
      SRST = 1'b0;
      step(1);
   endtask : do_reset
   initial begin
      {REG_WR, REG_RD, OFF_TIMER_EXPIRED} = 3'b000;
      REG_ADDR = 8'h00;
      REG_WDATA = 8'h00;
      key_closed = 16'h0000;
      ext_level = 8'hFF;
      seed = 32'h29a4;
      do_reset();
      foreach (alist[i]) rchk("reset value", alist[i], RST_VAL);
      chk("sink selects", 8'h03, {6'h00, LED2_SINK_SEL, LED3_SINK_SEL});
      chk("irq after reset", 8'h01, {7'h00, irq_n});
      wr(A_LEDEN, 8'h30);
      chk("sink released", 8'h00, {6'h00, LED2_SINK_SEL, LED3_SINK_SEL});
      seed = xs(seed);
      wr(A_DIR, 8'hF0);
      wr(A_OUTD, seed[7:0]);
      chk("pin enables", 8'hF0, PIN_OE);
      chk("pin outputs", seed[7:0] & 8'hF0, PIN_OUT & 8'hF0);
      wr(A_PULL, seed[15:8]);
      chk("pull-ups", seed[15:8], PIN_PULLUP);
      wr(A_PULL, 8'h00);
      ext_level = {4'hF, seed[19:16]};
      step(20);
      rd(A_INST, rdv);
      chk("input state", {4'h0, seed[19:16]}, rdv & 8'h0F);
      // a two-cycle glitch is shorter than the four-cycle debounce window
      ext_level[3] = ~ext_level[3];
      step(2);
      ext_level[3] = ~ext_level[3];
      step(20);
      rd(A_INST, rdv);
      chk("glitch filtered", {4'h0, seed[19:16]}, rdv & 8'h0F);
      ext_level = 8'hFF;
      wr(A_GILV, 8'h00);
      wr(A_GIEN, 8'h01);
      ext_level[1] = 1'b0;
      step(20);
      chk("masked input", 8'h01, {7'h00, irq_n});
      ext_level[0] = 1'b0;
      wait_irq(1'b0, 100);
      rchk("input flag", A_MODE, 8'h04);
      ext_level = 8'hFF;
      step(20);
      rchk("input status first", A_GIST, 8'h01);
      rchk("input status second", A_GIST, 8'h00);
      chk("irq before flag clear", 8'h00, {7'h00, irq_n});
      wr(A_MODE, 8'h04);
      step(2);
      chk("irq after flag clear", 8'h01, {7'h00, irq_n});
      do_reset();
      // host order: sinks off, row pull-ups, scanning, light enable, operating mode
      wr(A_LEDEN, 8'h30);
      wr(A_PULL, 8'h0F);
      wr(A_SCAN, 8'hFF);
      wr(A_IEN, 8'h03);
      wr(A_BLCTL, 8'h02);
      wr(A_MODE, 8'h80);
      wr(A_OUTD, 8'hFF);
      foreach (alist[i]) if (i >= 1 && i <= 4) rchk("rw readback", alist[i], shadow[alist[i]]);
      chk("idle columns driven", 8'hF0, PIN_OE & 8'hF0);
      chk("idle columns low", 8'h00, PIN_OUT & 8'hF0);
      chk("idle rows pulled", 8'h0F, PIN_PULLUP & 8'h0F);
      // a tap shorter than one sample period must not count
      key_closed[0] = 1'b1;
      step(30);
      key_closed[0] = 1'b0;
      step(700);
      chk("short tap", 8'h01, {7'h00, irq_n});
      for (int k = 0; k < 2; k++) begin
         seed = xs(seed);
         key = k * 8 + int'(seed[2:0]);
         key_q.push_back(key);
         key_closed[key] = 1'b1;
         step(100);
         chk("press too early", 8'h01, {7'h00, irq_n});
         wait_irq(1'b0, 1000);
         chk("backlight on", 8'h01, {7'h00, BACKLIGHT_ENABLE});
         e16 = 16'h0001 << key_q[0];
         rchk("press a-h", A_KPAH, e16[7:0]);
         rchk("press i-p", A_KPIP, e16[15:8]);
         wr(A_MODE, 8'hA1);
         step(2);
         chk("press cleared held", 8'h01, {7'h00, irq_n});
         key_closed[key] = 1'b0;
         wait_irq(1'b0, 1000);
         rchk("release a-h", A_KRAH, e16[7:0]);
         rchk("release i-p", A_KRIP, e16[15:8]);
         chk("back to idle", 8'hF0, PIN_OE & 8'hF0);
         void'(key_q.pop_front());
         wr(A_MODE, 8'hA2);
         step(2);
         chk("release cleared", 8'h01, {7'h00, irq_n});
         OFF_TIMER_EXPIRED = 1'b1;
         step(1);
         OFF_TIMER_EXPIRED = 1'b0;
         step(2);
         chk("backlight off", 8'h00, {7'h00, BACKLIGHT_ENABLE});
      end
      // a press flag left set blocks the next relight
      key_closed[5] = 1'b1;
      wait_irq(1'b0, 1000);
      chk("relit on press", 8'h01, {7'h00, BACKLIGHT_ENABLE});
      rchk("held press", A_KPAH, 8'h20);
      OFF_TIMER_EXPIRED = 1'b1;
      step(1);
      OFF_TIMER_EXPIRED = 1'b0;
      key_closed[5] = 1'b0;
      step(800);
      key_closed[5] = 1'b1;
      step(600);
      rchk("second press", A_KPAH, 8'h20);
      chk("no relight", 8'h00, {7'h00, BACKLIGHT_ENABLE});
      end_of_test();
   end
endmodule : testbench
